// ==== include/sspc_pkg.sv ====
// constants and types for the second-port bus configuration register
// Function
// - enable bit activates port and pin monitoring
// - slave inhibit suppresses slave interrupts only
// - busy set during transfer, cleared stop/free
// - hold extension bit selects SDA timing
// - timeout enable: timer reload while clock high
// - split timer: only upper byte held
// - bus free after ten-plus source periods high
// - two-bit field picks bit-rate overflow source
`default_nettype none
package sspc_pkg;
    localparam logic [7:0] SSPC_SFR_ADDR = 8'hc1;
    localparam logic [3:0] SSPC_SFR_PAGE = 4'hf;
    localparam logic [7:0] SSPC_CFG_RESET = 8'h00;
    // software-writable bits; the busy bit is read-only
    localparam logic [7:0] SSPC_WR_MASK = 8'hdf;
    localparam int SSPC_FREE_PERIODS = 10;
    localparam int SSPC_FREE_W = 4;

    typedef enum logic [1:0] {
        SSPC_SRC_T0,
        SSPC_SRC_T5,
        SSPC_SRC_T2HI,
        SSPC_SRC_T2LO
    } sspc_src_t;

    // register layout, msb first
    typedef struct packed {
        logic port_enable_bit;
        logic slave_inhibit_bit;
        logic transfer_busy_flag;
        logic hold_extension_enable;
        logic clock_low_timeout_enable;
        logic bus_free_timeout_enable;
        sspc_src_t bitrate_source_select;
    } sspc_cfg_t;

    // system-clock domain state
    typedef struct packed {
        sspc_cfg_t cfg;
        logic [7:0] rdata;
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] start_sync;
        logic [1:0] stop_sync;
        logic start_seen;
        logic stop_seen;
        logic [SSPC_FREE_W-1:0] free_cnt;
        logic bus_free;
        logic t4_reload_hi;
        logic t4_reload_lo;
        logic tick;
        logic slave_irq;
        logic master_irq;
        logic ext_hold;
        logic active;
    } sspc_core_t;

    // link-clock domain state
    typedef struct packed {
        logic [1:0] en_sync;
        logic [1:0] scl_pin;
        logic [1:0] sda_pin;
        logic scl_prev;
        logic sda_prev;
        logic start_tgl;
        logic stop_tgl;
    } sspc_link_t;
endpackage
`default_nettype wire

// ==== rtl/sspc_config.sv ====
// configuration, busy and timeout logic for the second bus port
`timescale 1ns/100ps
`default_nettype none
module sspc_config #(
    parameter int FREE_PERIODS = sspc_pkg::SSPC_FREE_PERIODS
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic LINK_CLK,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [3:0] SFR_PAGE,
    input wire logic SFR_WE,
    input wire logic SFR_RE,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    input wire logic PORT_CLOCK_LINE,
    input wire logic PORT_DATA_LINE,
    input wire logic T0_OVF,
    input wire logic T5_OVF,
    input wire logic T2HI_OVF,
    input wire logic T2LO_OVF,
    input wire logic T4_SPLIT,
    input wire logic SLAVE_EVENT,
    input wire logic MASTER_EVENT,
    output logic BITRATE_TICK,
    output logic T4_RELOAD_HI,
    output logic T4_RELOAD_LO,
    output logic EXT_HOLD,
    output logic SLAVE_IRQ,
    output logic MASTER_IRQ,
    output logic BUS_FREE,
    output logic PORT_ACTIVE,
    output logic BUSY
);
    sspc_pkg::sspc_core_t s_q;
    sspc_pkg::sspc_core_t s_d;
    sspc_pkg::sspc_link_t l_q;
    sspc_pkg::sspc_link_t l_d;
    localparam int SSPC_FREE_W_L = sspc_pkg::SSPC_FREE_W;
    logic sfr_hit;
    logic [SSPC_FREE_W_L-1:0] free_lim;

    assign sfr_hit = (SFR_ADDR == sspc_pkg::SSPC_SFR_ADDR)
        && (SFR_PAGE == sspc_pkg::SSPC_SFR_PAGE);
    assign free_lim = SSPC_FREE_W_L'(FREE_PERIODS + 1);

    // ==========================================================
    // link domain: pin sampling, start and stop detection
    // ==========================================================
    always_comb begin
        l_d = l_q;
        l_d.en_sync = {l_q.en_sync[0], s_q.cfg.port_enable_bit};
        l_d.scl_pin = {l_q.scl_pin[0], PORT_CLOCK_LINE};
        l_d.sda_pin = {l_q.sda_pin[0], PORT_DATA_LINE};
        l_d.scl_prev = l_q.scl_pin[1];
        l_d.sda_prev = l_q.sda_pin[1];
        // start: data falls while clock high
        if (l_q.en_sync[1] && l_q.scl_pin[1] && l_q.scl_prev
            && l_q.sda_prev && !l_q.sda_pin[1]) begin
            l_d.start_tgl = !l_q.start_tgl;
        end
        // stop: data rises while clock high
        if (l_q.en_sync[1] && l_q.scl_pin[1] && l_q.scl_prev
            && !l_q.sda_prev && l_q.sda_pin[1]) begin
            l_d.stop_tgl = !l_q.stop_tgl;
        end
    end

    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // ==========================================================
    // system domain: register, busy, timeouts, rate source
    // ==========================================================
    always_comb begin
        logic scl_hi;
        logic both_hi;
        logic start_ev;
        logic stop_ev;
        logic src_tick;
        sspc_pkg::sspc_cfg_t rd;
        scl_hi = 1'b0;
        both_hi = 1'b0;
        start_ev = 1'b0;
        stop_ev = 1'b0;
        src_tick = 1'b0;
        rd = s_q.cfg;
        s_d = s_q;
        // level and toggle crossings from the link domain
        s_d.scl_sync = {s_q.scl_sync[0], l_q.scl_pin[1]};
        s_d.sda_sync = {s_q.sda_sync[0], l_q.sda_pin[1]};
        s_d.start_sync = {s_q.start_sync[0], l_q.start_tgl};
        s_d.stop_sync = {s_q.stop_sync[0], l_q.stop_tgl};
        s_d.start_seen = s_q.start_sync[1];
        s_d.stop_seen = s_q.stop_sync[1];
        start_ev = s_q.start_sync[1] ^ s_q.start_seen;
        stop_ev = s_q.stop_sync[1] ^ s_q.stop_seen;
        scl_hi = s_q.scl_sync[1];
        both_hi = s_q.scl_sync[1] && s_q.sda_sync[1];

        // rate source select
        unique case (s_q.cfg.bitrate_source_select)
            sspc_pkg::SSPC_SRC_T0: src_tick = T0_OVF;
            sspc_pkg::SSPC_SRC_T5: src_tick = T5_OVF;
            sspc_pkg::SSPC_SRC_T2HI: src_tick = T2HI_OVF;
            sspc_pkg::SSPC_SRC_T2LO: src_tick = T2LO_OVF;
        endcase
        s_d.tick = src_tick;

        // bus-free timeout counts source periods with both lines high
        s_d.bus_free = 1'b0;
        if (!both_hi || !s_q.cfg.bus_free_timeout_enable
            || !s_q.cfg.port_enable_bit) begin
            s_d.free_cnt = '0;
        end else if (src_tick && s_q.free_cnt != free_lim) begin
            s_d.free_cnt = s_q.free_cnt + 1'b1;
            s_d.bus_free = (s_q.free_cnt + 1'b1) == free_lim;
        end

        // busy: disable clears first; otherwise set wins over stop/free clear
        if (!s_q.cfg.port_enable_bit) begin
            s_d.cfg.transfer_busy_flag = 1'b0;
        end else if (start_ev) begin
            s_d.cfg.transfer_busy_flag = 1'b1;
        end else if (stop_ev || s_q.bus_free) begin
            s_d.cfg.transfer_busy_flag = 1'b0;
        end

        // register write; busy bit is not writable
        if (SFR_WE && sfr_hit) begin
            s_d.cfg = sspc_pkg::sspc_cfg_t'(
                (SFR_WDATA & sspc_pkg::SSPC_WR_MASK)
                | (s_d.cfg & ~sspc_pkg::SSPC_WR_MASK));
        end
        s_d.rdata = (SFR_RE && sfr_hit) ? rd : 8'h00;

        // timer 4 reload gating
        s_d.t4_reload_hi = s_q.cfg.clock_low_timeout_enable
            && scl_hi;
        s_d.t4_reload_lo = s_q.cfg.clock_low_timeout_enable
            && scl_hi && !T4_SPLIT;

        s_d.slave_irq = SLAVE_EVENT && s_q.cfg.port_enable_bit
            && !s_q.cfg.slave_inhibit_bit;
        s_d.master_irq = MASTER_EVENT
            && s_q.cfg.port_enable_bit;
        s_d.ext_hold = s_q.cfg.hold_extension_enable;
        s_d.active = s_q.cfg.port_enable_bit;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign SFR_RDATA = s_q.rdata;
    assign BITRATE_TICK = s_q.tick;
    assign T4_RELOAD_HI = s_q.t4_reload_hi;
    assign T4_RELOAD_LO = s_q.t4_reload_lo;
    assign EXT_HOLD = s_q.ext_hold;
    assign SLAVE_IRQ = s_q.slave_irq;
    assign MASTER_IRQ = s_q.master_irq;
    assign BUS_FREE = s_q.bus_free;
    assign PORT_ACTIVE = s_q.active;
    assign BUSY = s_q.cfg.transfer_busy_flag;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    reload_hi_gate_a: assert property (
        s_q.cfg.clock_low_timeout_enable && s_q.scl_sync[1]
        |=> T4_RELOAD_HI)
        else $error("timer reload not held with clock high");
    reload_lo_split_a: assert property (
        T4_SPLIT |=> !T4_RELOAD_LO)
        else $error("low byte reloaded in split mode");
    slave_inhibit_a: assert property (
        s_q.cfg.slave_inhibit_bit |=> !SLAVE_IRQ)
        else $error("slave interrupt while inhibited");
    master_irq_a: assert property (
        MASTER_EVENT && s_q.cfg.port_enable_bit |=> MASTER_IRQ)
        else $error("master interrupt lost");
    rate_select_a: assert property (
        s_q.cfg.bitrate_source_select == sspc_pkg::SSPC_SRC_T5
        && T5_OVF |=> BITRATE_TICK)
        else $error("timer 5 overflow not selected");
    free_count_a: assert property (
        BUS_FREE |-> s_q.free_cnt == free_lim && BITRATE_TICK)
        else $error("bus free at wrong count");
    busy_clear_a: assert property (
        BUS_FREE && !(s_q.start_sync[1] ^ s_q.start_seen) |=> !BUSY)
        else $error("busy not cleared by free timeout");
    disabled_idle_a: assert property (
        !s_q.cfg.port_enable_bit |=> !BUSY && !PORT_ACTIVE)
        else $error("port active while disabled");
    hold_ext_a: assert property (
        SFR_WE && sfr_hit |=> ##1 EXT_HOLD == $past(SFR_WDATA[4], 2))
        else $error("hold extension not applied");

    // ==========================================================
    // checks on gating, busy, read, interrupt, rate, timeout and hold paths
    // ==========================================================
    reload_count_a: assert property (
        !s_q.scl_sync[1] |=> !T4_RELOAD_HI && !T4_RELOAD_LO)
        else $error("timer reload held with clock low");
    reload_off_a: assert property (
        !s_q.cfg.clock_low_timeout_enable
        |=> !T4_RELOAD_HI && !T4_RELOAD_LO)
        else $error("timer reload without timeout enable");
    reload_lo_full_a: assert property (
        s_q.cfg.clock_low_timeout_enable && s_q.scl_sync[1] && !T4_SPLIT
        |=> T4_RELOAD_LO)
        else $error("low byte not reloaded outside split mode");
    busy_set_a: assert property (
        (s_q.start_sync[1] ^ s_q.start_seen) && s_q.cfg.port_enable_bit
        |=> BUSY)
        else $error("busy not set by start");
    busy_stop_a: assert property (
        (s_q.stop_sync[1] ^ s_q.stop_seen)
        && !(s_q.start_sync[1] ^ s_q.start_seen) |=> !BUSY)
        else $error("busy not cleared by stop");
    busy_rise_a: assert property (
        !BUSY ##1 BUSY |-> $past(s_q.start_sync[1] ^ s_q.start_seen))
        else $error("busy set without start");
    read_value_a: assert property (
        SFR_RE && sfr_hit |=> SFR_RDATA == $past(s_q.cfg))
        else $error("register read does not match state");
    slave_irq_a: assert property (
        SLAVE_EVENT && s_q.cfg.port_enable_bit && !s_q.cfg.slave_inhibit_bit
        |=> SLAVE_IRQ)
        else $error("slave interrupt lost");
    irq_disabled_a: assert property (
        !s_q.cfg.port_enable_bit |=> !SLAVE_IRQ && !MASTER_IRQ)
        else $error("interrupt from disabled port");
    slave_quiet_a: assert property (
        !SLAVE_EVENT |=> !SLAVE_IRQ)
        else $error("slave interrupt without event");
    master_quiet_a: assert property (
        !MASTER_EVENT |=> !MASTER_IRQ)
        else $error("master interrupt without event");
    rate_t0_a: assert property (
        s_q.cfg.bitrate_source_select == sspc_pkg::SSPC_SRC_T0
        && T0_OVF |=> BITRATE_TICK)
        else $error("timer 0 overflow not selected");
    rate_t2hi_a: assert property (
        s_q.cfg.bitrate_source_select == sspc_pkg::SSPC_SRC_T2HI
        && T2HI_OVF |=> BITRATE_TICK)
        else $error("timer 2 high overflow not selected");
    rate_t2lo_a: assert property (
        s_q.cfg.bitrate_source_select == sspc_pkg::SSPC_SRC_T2LO
        && T2LO_OVF |=> BITRATE_TICK)
        else $error("timer 2 low overflow not selected");
    rate_mute_a: assert property (
        s_q.cfg.bitrate_source_select == sspc_pkg::SSPC_SRC_T0
        && !T0_OVF |=> !BITRATE_TICK)
        else $error("tick without selected overflow");
    free_clear_a: assert property (
        !s_q.cfg.bus_free_timeout_enable
        |=> s_q.free_cnt == '0 && !BUS_FREE)
        else $error("free counter runs while disabled");
    free_lines_a: assert property (
        !(s_q.scl_sync[1] && s_q.sda_sync[1])
        |=> s_q.free_cnt == '0 && !BUS_FREE)
        else $error("free counter runs with a line low");
    active_follow_a: assert property (
        s_q.cfg.port_enable_bit |=> PORT_ACTIVE)
        else $error("port not active while enabled");
    hold_set_a: assert property (
        s_q.cfg.hold_extension_enable |=> EXT_HOLD)
        else $error("extended timing not selected");
    hold_clear_a: assert property (
        !s_q.cfg.hold_extension_enable |=> !EXT_HOLD)
        else $error("normal timing not selected");

    busy_set_c: cover property (!BUSY ##1 BUSY);
    irq_c: cover property (MASTER_IRQ && !SLAVE_IRQ);
    clock_low_c: cover property (
        s_q.cfg.clock_low_timeout_enable && !T4_RELOAD_HI);
    free_c: cover property (BUS_FREE);
    split_c: cover property (T4_RELOAD_HI && !T4_RELOAD_LO);
endmodule
`default_nettype wire

// ==== sim/sspc_bus_model.sv ====
// other masters sharing the second port's wires
`timescale 1ns/100ps
`default_nettype none
module sspc_bus_model (
    output logic SCL,
    output logic SDA
);
    // ====
    // wire sequences, one step per 500 ns
    initial begin
        SCL = 1'b1;
        SDA = 1'b1;
    end
    task automatic step(input logic c, input logic d);
        #500;
        SCL = c;
        SDA = d;
    endtask
    task automatic set_clock(input logic c);
        step(c, SDA);
    endtask
    task automatic start_cond();
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    // data rises while clock low, so no stop is made
    task automatic quiet_release();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
    endtask
    task automatic stop_cond();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the second-port configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int FP = 2;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'hc1;
    logic [3:0] page = 4'hf;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [5:0] ev = 6'h00;
    logic split = 1'b0;
    wire logic scl;
    wire logic sda;
    logic [7:0] rdata;
    logic tick, rhi, rlo, xhold, sirq, mirq, bfree, act, busy;
    logic [3:0] seen;
    int err_total = 0;
    int n_compared = 0;
    always #25 clk = ~clk;
    initial begin
        #10;
        forever #62.5 lclk = ~lclk;
    end
    sspc_config #(.FREE_PERIODS(FP)) dut_u (.CLK(clk), .RST_N(rst_n),
        .LINK_CLK(lclk), .SFR_ADDR(addr), .SFR_PAGE(page), .SFR_WE(we),
        .SFR_RE(re), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .PORT_CLOCK_LINE(scl), .PORT_DATA_LINE(sda), .T0_OVF(ev[0]),
        .T5_OVF(ev[1]), .T2HI_OVF(ev[2]), .T2LO_OVF(ev[3]),
        .T4_SPLIT(split), .SLAVE_EVENT(ev[4]), .MASTER_EVENT(ev[5]),
        .BITRATE_TICK(tick), .T4_RELOAD_HI(rhi), .T4_RELOAD_LO(rlo),
        .EXT_HOLD(xhold), .SLAVE_IRQ(sirq), .MASTER_IRQ(mirq),
        .BUS_FREE(bfree), .PORT_ACTIVE(act), .BUSY(busy));
    sspc_bus_model bm_u (.SCL(scl), .SDA(sda));
    // ====
    // access and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [3:0] p, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        page = p;
        we = w;
        re = !w;
        wdata = d;
        @(negedge clk);
        we = 1'b0;
        re = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] p,
        input logic [7:0] exp);
        acc(1'b0, a, p, 8'h00);
        chk(rdata, exp);
    endtask
    // one input pulse, outputs gathered over three cycles
    task automatic fire(input int i);
        seen = 4'h0;
        @(negedge clk);
        ev[i] = 1'b1;
        repeat (3) begin
            @(negedge clk);
            ev = 6'h00;
            seen |= {bfree, mirq, sirq, tick};
        end
    endtask
    task automatic wait_busy(input logic v);
        int k;
        k = 0;
        while (busy !== v && k < 80) begin
            @(negedge clk);
            k++;
        end
        chk({7'h0, busy}, {7'h0, v});
    endtask
    task automatic summarize();
        $display("compares=%0d mismatches=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ====
    // watchdog, far beyond the expected run
    initial begin
        #2000000;
        err_total++;
        summarize();
    end
    // ====
    // tests
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        rd(8'hc1, 4'hf, 8'h00);
        acc(1'b1, 8'hc1, 4'hf, 8'hff);
        rd(8'hc1, 4'hf, 8'hdf);
        chk({6'h0, act, xhold}, 8'h03);
        rd(8'hc2, 4'hf, 8'h00);
        acc(1'b1, 8'hc1, 4'h0, 8'h00);
        acc(1'b1, 8'hc1, 4'hf, 8'h40);
        rd(8'hc1, 4'hf, 8'h40);
        chk({6'h0, act, xhold}, 8'h00);
        for (int s = 0; s < 4; s++) begin
            acc(1'b1, 8'hc1, 4'hf, 8'h80 | 8'(s));
            for (int i = 0; i < 4; i++) begin
                fire(i);
                chk({7'h0, seen[0]}, {7'h0, i == s});
            end
        end
        for (int h = 0; h < 2; h++) begin
            acc(1'b1, 8'hc1, 4'hf, h ? 8'hc0 : 8'h80);
            fire(4);
            chk({6'h0, seen[2:1]}, h ? 8'h00 : 8'h01);
            fire(5);
            chk({6'h0, seen[2:1]}, 8'h02);
        end
        acc(1'b1, 8'hc1, 4'hf, 8'h88);
        repeat (20) @(negedge clk);
        chk({6'h0, rhi, rlo}, 8'h03);
        split = 1'b1;
        repeat (3) @(negedge clk);
        chk({6'h0, rhi, rlo}, 8'h02);
        bm_u.set_clock(1'b0);
        repeat (20) @(negedge clk);
        chk({6'h0, rhi, rlo}, 8'h00);
        // bench stands in for the timer 4 handler: drop the port to recover
        acc(1'b1, 8'hc1, 4'hf, 8'h08);
        bm_u.set_clock(1'b1);
        split = 1'b0;
        // start on a disabled port stays unseen
        acc(1'b1, 8'hc1, 4'hf, 8'h04);
        bm_u.start_cond();
        repeat (60) @(negedge clk);
        chk({7'h0, busy}, 8'h00);
        bm_u.stop_cond();
        acc(1'b1, 8'hc1, 4'hf, 8'h84);
        bm_u.start_cond();
        wait_busy(1'b1);
        rd(8'hc1, 4'hf, 8'ha4);
        bm_u.stop_cond();
        wait_busy(1'b0);
        bm_u.start_cond();
        wait_busy(1'b1);
        bm_u.quiet_release();
        repeat (20) @(negedge clk);
        for (int i = 0; i < FP; i++)
            fire(0);
        chk({7'h0, busy}, 8'h01);
        fire(0);
        chk({7'h0, seen[3]}, 8'h01);
        wait_busy(1'b0);
        summarize();
    end
endmodule
`default_nettype wire
